/* File: rtl/scf_pkg.sv */
// Package holding offsets, field layouts and reset values of the context fault registers.
package scf_pkg;
	// Register byte offsets on the bus.
	localparam logic [7:0] OFS_XLATE_CMD = 8'h00;
	localparam logic [7:0] OFS_XLATE_STATUS = 8'h04;
	localparam logic [7:0] OFS_CONTEXT_ID = 8'h08;
	localparam logic [7:0] OFS_FAULT_ADDR = 8'h0c;
	localparam logic [7:0] OFS_FAULT_STATUS = 8'h10;
	localparam logic [7:0] OFS_RESULT = 8'h14;
	localparam logic [7:0] OFS_TABLE_CTRL = 8'h18;
	localparam logic [7:0] OFS_TABLE_BASE_ID = 8'h1c;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
	// Field positions.
	localparam int CMD_ADDR_LSB = 12;
	localparam int STATUS_ACTIVE_BIT = 0;
	localparam int CTX_ADDRESS_SPACE_IDENTIFIER_MSB = 7;
	localparam int CTRL_LONG_FMT_BIT = 0;
	localparam int FSTAT_DEFINED_BIT = 30;
	localparam int FAULT_ADDR_WIDTH = 32;
	localparam int IRQ_XLATE_DONE_BIT = 0;
	localparam int IRQ_FAULT_BIT = 1;
	// Reset values.
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic RST_FSTAT_BIT30 = 1'b0;
	localparam logic [1:0] RST_IRQ = 2'h0;
	// Walk count at which the translation engine moves on to write the result.
	localparam logic [3:0] XLATE_CYCLES = 4'h4;
	// AHB transfer codes.
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage

/* File: rtl/scf_regs.sv */
// Stage one context bank fault and translation register set on AHB-Lite.
`timescale 1ns/1ps
module scf_regs (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic fault_valid_i,
	input wire logic [31:0] fault_addr_i,
	input wire logic [31:0] fault_bits_i,
	output logic [7:0] address_space_identifier_o,
	output logic [31:0] xlate_base_o,
	output logic irq_o
);
	typedef enum logic [1:0] {SCF_IDLE, SCF_WALK, SCF_DONE} scf_state_e;

	logic ap_valid;
	logic ap_write;
	logic [7:0] ap_addr;
	logic [31:0] context_identity;
	logic [31:0] fault_input_address;
	logic [31:0] fault_status;
	logic [31:0] translation_result;
	logic long_format_select;
	logic [7:0] table_base_address_space_identifier;
	logic [19:0] pending_addr;
	logic [3:0] walk_count;
	logic active;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	scf_state_e state;
	scf_state_e next_state;

	// Address phase decode; the slave always answers with zero wait states.
	wire take_ap = hsel_i & hready_i & (htrans_i == scf_pkg::HTRANS_NONSEQ
		| htrans_i == scf_pkg::HTRANS_SEQ);
	wire wr = ap_valid & ap_write;
	wire wr_cmd = wr & (ap_addr == scf_pkg::OFS_XLATE_CMD);
	wire wr_ctx = wr & (ap_addr == scf_pkg::OFS_CONTEXT_ID);
	wire wr_fltaddr = wr & (ap_addr == scf_pkg::OFS_FAULT_ADDR);
	wire wr_fstat = wr & (ap_addr == scf_pkg::OFS_FAULT_STATUS);
	wire wr_ctrl = wr & (ap_addr == scf_pkg::OFS_TABLE_CTRL);
	wire wr_tbid = wr & (ap_addr == scf_pkg::OFS_TABLE_BASE_ID);
	wire wr_irqs = wr & (ap_addr == scf_pkg::OFS_IRQ_STATUS);
	wire wr_irqm = wr & (ap_addr == scf_pkg::OFS_IRQ_MASK);
	wire cmd_accept = wr_cmd & (state == SCF_IDLE);
	wire result_write = (state == SCF_DONE);

	// Translation engine: identity map, tagged with the active address space id.
	wire [7:0] eff_address_space_identifier = long_format_select ? table_base_address_space_identifier
		: context_identity[scf_pkg::CTX_ADDRESS_SPACE_IDENTIFIER_MSB:0];
	wire [31:0] next_result = {pending_addr, 4'h0, eff_address_space_identifier};

	// Fault status next value: hardware set beats software clear.
	wire [31:0] fstat_clr = wr_fstat ? hwdata_i : scf_pkg::RST_ZERO;
	wire [31:0] fstat_set = fault_valid_i ? fault_bits_i : scf_pkg::RST_ZERO;
	wire [31:0] next_fstat = (fault_status & ~fstat_clr) | fstat_set;

	// Interrupt events and their write-one-to-clear status.
	wire [1:0] irq_evt = {fault_valid_i, result_write};
	wire [1:0] irq_clr = wr_irqs ? hwdata_i[1:0] : scf_pkg::RST_IRQ;
	wire [1:0] next_irq_status = (irq_status & ~irq_clr) | irq_evt;

	// Byte offset of the current address phase; out-of-window maps to unused.
	wire [7:0] bus_addr = (haddr_i[31:8] == 24'h0) ? haddr_i[7:0] : 8'hff;
	wire rd_take = take_ap & ~hwrite_i;

	// Read data multiplexer; command and unmapped locations read zero.
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = scf_pkg::RST_ZERO;
		unique case (bus_addr)
			scf_pkg::OFS_XLATE_STATUS: rd_mux = {31'h0, active};
			scf_pkg::OFS_CONTEXT_ID: rd_mux = context_identity;
			scf_pkg::OFS_FAULT_ADDR: rd_mux = fault_input_address;
			scf_pkg::OFS_FAULT_STATUS: rd_mux = fault_status;
			scf_pkg::OFS_RESULT: rd_mux = translation_result;
			scf_pkg::OFS_TABLE_CTRL: rd_mux = {31'h0, long_format_select};
			scf_pkg::OFS_TABLE_BASE_ID: rd_mux = {24'h0, table_base_address_space_identifier};
			scf_pkg::OFS_IRQ_STATUS: rd_mux = {30'h0, irq_status};
			scf_pkg::OFS_IRQ_MASK: rd_mux = {30'h0, irq_mask};
			default: rd_mux = scf_pkg::RST_ZERO;
		endcase
	end

	// Translation sequencer.
	always_comb begin
		next_state = state;
		unique case (state)
			SCF_IDLE: if (cmd_accept) next_state = SCF_WALK;
			SCF_WALK: if (walk_count == scf_pkg::XLATE_CYCLES) begin
				next_state = SCF_DONE;
			end
			SCF_DONE: next_state = SCF_IDLE;
		endcase
	end

	// Bus address phase capture and data phase read answer.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ap_valid <= 1'b0;
			ap_write <= 1'b0;
			ap_addr <= 8'h00;
			hrdata_o <= scf_pkg::RST_ZERO;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end else begin
			ap_valid <= take_ap;
			ap_write <= hwrite_i;
			ap_addr <= bus_addr;
			// Read data is loaded at the address edge so it stands in the data phase.
			hrdata_o <= rd_take ? rd_mux : scf_pkg::RST_ZERO;
		end
	end

	// Translation command, active flag and result.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state <= SCF_IDLE;
			active <= 1'b0;
			walk_count <= 4'h0;
			pending_addr <= 20'h0;
			translation_result <= scf_pkg::RST_ZERO;
		end else begin
			state <= next_state;
			walk_count <= (state == SCF_WALK) ? walk_count + 4'h1 : 4'h0;
			if (cmd_accept) begin
				pending_addr <= hwdata_i[31:scf_pkg::CMD_ADDR_LSB];
				active <= 1'b1;
			end
			if (result_write) begin
				translation_result <= next_result;
				active <= 1'b0;
			end
		end
	end

	// Context, table control and fault capture registers.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			context_identity <= scf_pkg::RST_ZERO;
			long_format_select <= 1'b0;
			table_base_address_space_identifier <= 8'h00;
			fault_input_address <= scf_pkg::RST_ZERO;
			fault_status <= scf_pkg::RST_ZERO;
			// Bit 30 takes its own reset value over the zero loaded above.
			fault_status[scf_pkg::FSTAT_DEFINED_BIT] <= scf_pkg::RST_FSTAT_BIT30;
		end else begin
			if (wr_ctx) context_identity <= hwdata_i;
			if (wr_ctrl) long_format_select <= hwdata_i[scf_pkg::CTRL_LONG_FMT_BIT];
			if (wr_tbid) table_base_address_space_identifier <= hwdata_i[7:0];
			if (wr_fltaddr) fault_input_address <= hwdata_i;
			if (fault_valid_i) fault_input_address <= fault_addr_i;
			fault_status <= next_fstat;
		end
	end

	// Interrupt status, mask, line and translation-side outputs.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			irq_status <= scf_pkg::RST_IRQ;
			irq_mask <= scf_pkg::RST_IRQ;
			irq_o <= 1'b0;
			address_space_identifier_o <= 8'h00;
			xlate_base_o <= scf_pkg::RST_ZERO;
		end else begin
			irq_status <= next_irq_status;
			if (wr_irqm) irq_mask <= hwdata_i[1:0];
			irq_o <= |(next_irq_status & irq_mask);
			address_space_identifier_o <= eff_address_space_identifier;
			xlate_base_o <= translation_result;
		end
	end
endmodule

/* File: verif/scf_chk.sv */
// Checker of bus answers, reset state and the busy flag.
`timescale 1ns/1ps
module scf_chk (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic [7:0] address_space_identifier_o,
	input wire logic irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// Decoded address phases of command and status accesses.
	wire logic ap = hsel_i && hready_i && htrans_i[1];
	wire logic ac = haddr_i[7:0] == scf_pkg::OFS_XLATE_CMD;
	wire logic as = haddr_i[7:0] == scf_pkg::OFS_XLATE_STATUS;
	logic [3:0] since;
	// Counts cycles since the last command write, saturating at 15.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			since <= 4'hf;
		end else if (ap && hwrite_i && ac) begin
			since <= 4'h0;
		end else if (since != 4'hf) begin
			since <= since + 4'h1;
		end
	end
	sequence cmd_s;
		ap && hwrite_i && ac;
	endsequence
	sequence stat_s;
		ap && !hwrite_i && as;
	endsequence
	ready_high_a: assert property (hreadyout_o) else $error("wait state");
	okay_resp_a: assert property (!hresp_o) else $error("error response");
	cmd_raz_a: assert property (ap && !hwrite_i && ac |=> hrdata_o == 32'h0)
		else $error("command read not zero");
	status_rsvd_a: assert property (stat_s |=> hrdata_o[31:1] == 31'h0)
		else $error("status reserved bits set");
	busy_set_a: assert property (cmd_s ##[2:7] stat_s |=> hrdata_o[0])
		else $error("busy flag missing");
	busy_clear_a: assert property (stat_s and since > 4'h9 |=> !hrdata_o[0])
		else $error("busy flag stuck");
	reset_irq_a: assert property ($fell(sys_rst_i) |-> !irq_o)
		else $error("irq after reset");
	reset_bus_a: assert property ($fell(sys_rst_i) |-> address_space_identifier_o == 8'h0)
		else $error("address_space_identifier after reset");
endmodule
bind scf_regs scf_chk i_scf_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
	.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
	.hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
	.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .address_space_identifier_o(address_space_identifier_o),
	.irq_o(irq_o));

/* File: verif/stage1_context_fault_regs_tb.sv */
// Self-checking bench for the context fault register set.
`timescale 1ns/1ps
module stage1_context_fault_regs_tb;
	logic clk_i = 0;
	logic sys_rst_i = 1;
	logic hw = 0;
	logic fv = 0;
	logic a;
	logic [1:0] ht = 0;
	logic [31:0] ha = 0, hd = 0, fa = 0, fb = 0, rv;
	wire logic [31:0] hrdata_o, xb;
	wire logic hready, hresp, irq_o;
	wire logic [7:0] address_space_identifier_o;
	int fail_count = 0;
	int tests_run = 0;
	always #20 clk_i = ~clk_i;
	scf_regs i_scf_regs (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(1'b1),
		.haddr_i(ha), .htrans_i(ht), .hwrite_i(hw), .hsize_i(3'h2),
		.hwdata_i(hd), .hready_i(hready), .hrdata_o(hrdata_o),
		.hreadyout_o(hready), .hresp_o(hresp), .fault_valid_i(fv),
		.fault_addr_i(fa), .fault_bits_i(fb), .address_space_identifier_o(address_space_identifier_o),
		.xlate_base_o(xb), .irq_o(irq_o));
	// Prints the counts and the verdict, then stops.
	task wrap_up;
		$display("checks %0d bad %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Compares a seen value with the expected one.
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	// Waits for hready at a rising edge, with a bound.
	task rdy;
		int n;
		n = 0;
		@(posedge clk_i);
		while (hready !== 1'b1) begin
			n++;
			if (n > 50) begin
				fail_count++;
				wrap_up;
			end
			@(posedge clk_i);
		end
	endtask
	// One single word transfer; read data lands in rv.
	task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
		ht <= scf_pkg::HTRANS_NONSEQ;
		hw <= w;
		ha <= {24'h0, ad};
		rdy;
		ht <= 2'h0;
		hd <= d;
		rdy;
		rv = hrdata_o;
	endtask
	// Main sequence of tests.
	initial begin
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 0;
		@(posedge clk_i);
		bus(0, scf_pkg::OFS_FAULT_STATUS, 0);
		chk("fstat30", {31'h0, rv[30]}, {31'h0, scf_pkg::RST_FSTAT_BIT30});
		$display("done reset");
		bus(1, scf_pkg::OFS_XLATE_CMD, 32'habcde123);
		bus(0, scf_pkg::OFS_XLATE_CMD, 0);
		chk("cmd", rv, 32'h0);
		bus(0, scf_pkg::OFS_XLATE_STATUS, 0);
		chk("busy", rv, 1);
		repeat (8) @(posedge clk_i);
		bus(1, scf_pkg::OFS_XLATE_STATUS, 32'hffffffff);
		bus(0, scf_pkg::OFS_XLATE_STATUS, 0);
		chk("idle", rv, 32'h0);
		bus(0, scf_pkg::OFS_RESULT, 0);
		chk("result", rv, 32'habcde000);
		chk("base", xb, 32'habcde000);
		$display("done translate");
		bus(1, scf_pkg::OFS_TABLE_CTRL, 0);
		bus(1, scf_pkg::OFS_CONTEXT_ID, 32'h12345678);
		bus(0, scf_pkg::OFS_CONTEXT_ID, 0);
		chk("ctx", rv, 32'h12345678);
		chk("address_space_identifier", {24'h0, address_space_identifier_o}, 32'h78);
		bus(1, scf_pkg::OFS_TABLE_BASE_ID, 32'h5a);
		bus(1, scf_pkg::OFS_TABLE_CTRL, 1);
		bus(0, scf_pkg::OFS_CONTEXT_ID, 0);
		chk("ctxl", rv, 32'h12345678);
		chk("asidl", {24'h0, address_space_identifier_o}, 32'h5a);
		$display("done context");
		fa <= 32'hdeadbeef;
		fb <= 32'h40000003;
		fv <= 1;
		@(posedge clk_i);
		fv <= 0;
		bus(0, scf_pkg::OFS_FAULT_ADDR, 0);
		chk("fltaddr", rv, 32'hdeadbeef);
		bus(1, scf_pkg::OFS_FAULT_STATUS, 1);
		bus(0, scf_pkg::OFS_FAULT_STATUS, 0);
		chk("fstat", rv, 32'h40000002);
		bus(1, scf_pkg::OFS_FAULT_ADDR, 32'h13572468);
		bus(0, scf_pkg::OFS_FAULT_ADDR, 0);
		chk("fltaddrw", rv, 32'h13572468);
		bus(1, scf_pkg::OFS_IRQ_MASK, 0);
		repeat (2) @(posedge clk_i);
		a = irq_o;
		chk("masked", {31'h0, a}, 32'h0);
		bus(1, scf_pkg::OFS_IRQ_MASK, 3);
		repeat (2) @(posedge clk_i);
		chk("mask", {31'h0, irq_o}, 32'h1);
		bus(1, scf_pkg::OFS_IRQ_STATUS, 3);
		bus(0, scf_pkg::OFS_IRQ_STATUS, 0);
		chk("irqs", rv, 32'h0);
		chk("irq", {31'h0, irq_o}, 32'h0);
		$display("done fault");
		wrap_up;
	end
endmodule
